// ---- hdl/ofr_defs.svh ----
// Constants for the output fault and restart supervisor.
`ifndef OFR_DEFS_SVH
`define OFR_DEFS_SVH

// Bus command codes.
`define OFR_CMD_OPERATION 8'h01
`define OFR_CMD_VOUT 8'h21
`define OFR_CMD_OV_RESP 8'h41
`define OFR_CMD_OC_RESP 8'h47
`define OFR_CMD_OT_RESP 8'h50

// Field positions inside command data.
`define OFR_OPERATION_ON_BIT 7
`define OFR_RESP_LATCH_BIT 6

// Reset setpoint and alarm bit positions.
`define OFR_DEFAULT_SETPOINT 16'h3400
`define OFR_ALARM_OC 0
`define OFR_ALARM_OT 1
`define OFR_ALARM_OV 2
`define OFR_ALARM_INLOW 3

// Time base: one tick per millisecond.
`define OFR_CLK_PERIOD_PS 32'h0000_1388
`define OFR_TICK_PS 32'h3b9a_ca00
`define OFR_TICK_CYCLES (`OFR_TICK_PS / `OFR_CLK_PERIOD_PS)

// Supervisory times in milliseconds, and the overvoltage try limit.
`define OFR_STARTUP_MS 16'h4e20
`define OFR_OC_DELAY_MS 16'h0bb8
`define OFR_OV_RETRY_MS 16'h03e8
`define OFR_OV_WINDOW_MS 16'hea60
`define OFR_OFF_MIN_MS 16'h07d0
`define OFR_AUX_LEAD_MS 16'h01c2
`define OFR_BLINK_MS 16'h01f4
`define OFR_OV_MAX_TRIES 2'h3

// Timer slots.
`define OFR_NUM_TIMERS 5
`define OFR_T_START 0
`define OFR_T_OC 1
`define OFR_T_STATE 2
`define OFR_T_WIN 3
`define OFR_T_OFF 4

`endif

// ---- hdl/ofr_pkg.sv ----
// Types shared by the output fault and restart supervisor.
package ofr_pkg;

   // Main sequencer states, one-hot.
   typedef enum logic [4:0] {
      OFR_ST_OFF = 5'h01,
      OFR_ST_AUX = 5'h02,
      OFR_ST_ON = 5'h04,
      OFR_ST_RETRY = 5'h08,
      OFR_ST_LATCH = 5'h10
   } ofr_state_t;

   typedef logic [15:0] ofr_ms_t;

endpackage

// ---- hdl/ofr_tick.sv ----
// Millisecond tick generator that drives every supervisory timer.
`timescale 1ns/1ps
`default_nettype none
`include "ofr_defs.svh"
module ofr_tick #(
   parameter int unsigned TICK_CYCLES = `OFR_TICK_CYCLES
)(
   input wire logic clk,
   input wire logic rst_b,
   output logic tick
);
   typedef struct packed {
      logic [31:0] cnt;
      logic tick;
   } ofr_tick_s_t;

   ofr_tick_s_t s_ff;
   ofr_tick_s_t nxt_s;

   // Free-running divider; the tick is one clock wide.
   always_comb
   begin
      nxt_s = s_ff;
      nxt_s.tick = 1'b0;
      if (s_ff.cnt >= TICK_CYCLES - 1)
      begin
         nxt_s.cnt = 32'h0;
         nxt_s.tick = 1'b1;
      end
      else
      begin
         nxt_s.cnt = s_ff.cnt + 32'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         s_ff <= '0;
      else
         s_ff <= nxt_s;
   end

   assign tick = s_ff.tick;
endmodule
`default_nettype wire

// ---- hdl/ofr_timer.sv ----
// Millisecond timer that counts while its condition holds.
`timescale 1ns/1ps
`default_nettype none
module ofr_timer (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic tick,
   input wire logic run,
   output ofr_pkg::ofr_ms_t count
);
   import ofr_pkg::*;

   typedef struct packed {
      ofr_ms_t cnt;
   } ofr_timer_s_t;

   ofr_timer_s_t s_ff;
   ofr_timer_s_t nxt_s;

   // Cleared as soon as the condition ends; saturates instead of wrapping.
   always_comb
   begin
      nxt_s = s_ff;
      if (!run)
         nxt_s.cnt = 16'h0;
      else if (tick && s_ff.cnt != 16'hffff)
         nxt_s.cnt = s_ff.cnt + 16'h1;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         s_ff <= '0;
      else
         s_ff <= nxt_s;
   end

   assign count = s_ff.cnt;
endmodule
`default_nettype wire

// ---- hdl/ofr_supervisor.sv ----
// Output fault, restart and indicator supervisor of the rectifier main output.
//
// What this block does
// (R1) Without bus control, setpoint follows pin below threshold, else default setpoint.
// (R2) Once the bus setpoint command runs, the pin is ignored for good.
// (R3) Hold constant current under overload for the startup window, then protect.
// (R4) In limit above the low-voltage threshold, blink the output indicator.
// (R5) In limit below the low-voltage threshold in restart mode, go hiccup.
// (R6) Output indicator steady on while on, off when off or latched.
// (R7) Postpone overcurrent shutdown by a fixed delay so loads can shed.
// (R8) Output below deep-overload voltage means short: shut down at once.
// (R9) Overcurrent and overtemperature auto-restart by default; bus selects per fault.
// (R10) With latch-off selected, stay off until a valid restart mechanism.
// (R11) After overvoltage, retry up to two times, each after a delay.
// (R12) Three failed overvoltage attempts within the window latch the output off.
// (R13) Fewer than three overvoltage shutdowns in the window clears the count.
// (R14) Cycling the on/off pin off then on restarts a latched unit.
// (R15) Bus operation off then on restarts a latched unit.
// (R16) Changing fault response from latch-off to restart releases the latch.
// (R17) Every restart but the configuration change and the overvoltage retry needs a minimum off time.
// (R18) Successful restart clears alarms and sets the restart-succeeded flag.
// (R19) Host restarts paralleled units with broadcast off/on or enable toggle.
// (R20) Host keeps units off long enough for a synchronized restart.
// (R21) Standby rail is up a lead time before the main output regulates.
// (R22) Input indicator blinks while input is below the low-line threshold.
// (R23) All delays count one time base; each counter clears with its condition.
`timescale 1ns/1ps
`default_nettype none
`include "ofr_defs.svh"
module ofr_supervisor #(
   parameter int unsigned TICK_CYCLES = `OFR_TICK_CYCLES
)(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic [15:0] cmd_data,
   input wire logic unit_enable,
   input wire logic prog_pin_below,
   input wire logic [15:0] prog_pin_code,
   input wire logic in_limit,
   input wire logic overcurrent,
   input wire logic overvoltage,
   input wire logic overtemp,
   input wire logic vout_below_low,
   input wire logic vout_below_short,
   input wire logic main_in_reg,
   input wire logic input_low,
   output logic [15:0] output_voltage_setpoint,
   output logic bus_control,
   output logic main_enable,
   output logic standby_rail,
   output logic cc_hold,
   output logic hiccup,
   output logic latched_off,
   output logic restart_ok,
   output logic [3:0] alarm,
   output logic out_led,
   output logic in_led
);
   import ofr_pkg::*;

   typedef struct packed {
      ofr_state_t state;
      logic [15:0] setpoint;
      logic bus_ctl;
      logic op_on;
      logic oc_latch;
      logic ot_latch;
      logic off_ok;
      logic restarting;
      logic retry_ov;
      logic latch_oc;
      logic latch_ot;
      logic [1:0] ov_cnt;
      logic [3:0] alarm;
      logic restart_ok;
      logic hiccup;
      logic cc_hold;
      logic main_en;
      logic standby_en;
      logic out_led;
      logic in_led;
      ofr_ms_t blink_cnt;
      logic blink_ph;
   } ofr_main_s_t;

   // Power-up counts as a full off interval, and the unit starts commanded on.
   localparam ofr_main_s_t ST_RST = '{state: OFR_ST_OFF, setpoint: `OFR_DEFAULT_SETPOINT,
      op_on: 1'b1, off_ok: 1'b1, default: '0};

   ofr_main_s_t s_ff;
   ofr_main_s_t nxt_s;
   logic tick;
   logic [`OFR_NUM_TIMERS-1:0] t_run;
   ofr_ms_t t_cnt [`OFR_NUM_TIMERS];
   logic want_on;
   logic cc_window;

   // Latch-off selection sits in the same bit of the overcurrent and overtemperature response commands.
   function automatic logic resp_latch(input logic [15:0] data);
      resp_latch = data[`OFR_RESP_LATCH_BIT];
   endfunction

   ofr_tick #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tick (
      .clk(clk),
      .rst_b(rst_b),
      .tick(tick)
   );

   // Five timers for the supervisory delays, all on the same millisecond tick.
   genvar gi;
   generate
      for (gi = 0; gi < `OFR_NUM_TIMERS; gi++)
      begin : g_tmr
         ofr_timer u_tmr (
            .clk(clk),
            .rst_b(rst_b),
            .tick(tick),
            .run(t_run[gi]),
            .count(t_cnt[gi])
         );
      end
   endgenerate

   // The unit is requested on only when both the pin and the bus agree.
   assign want_on = unit_enable & s_ff.op_on;
   assign cc_window = (t_cnt[`OFR_T_START] < `OFR_STARTUP_MS);

   // Timer run conditions; each timer clears as soon as its condition drops.
   always_comb
   begin
      t_run = '0;
      t_run[`OFR_T_START] = (s_ff.state == OFR_ST_ON); // R23
      t_run[`OFR_T_OC] = (s_ff.state == OFR_ST_ON) && overcurrent && !cc_window; // R7
      // Cleared on every change of state, so the standby lead after a retry counts from zero.
      t_run[`OFR_T_STATE] = ((s_ff.state == OFR_ST_AUX) || (s_ff.state == OFR_ST_RETRY))
         && (nxt_s.state == s_ff.state); // R21
      t_run[`OFR_T_WIN] = (s_ff.ov_cnt != 2'h0); // R11
      t_run[`OFR_T_OFF] = !want_on; // R17
   end

   // Next-state logic for the whole supervisor.
   always_comb
   begin
      nxt_s = s_ff;
      nxt_s.standby_en = 1'b1; // R21
      nxt_s.cc_hold = 1'b0;

      // The pin drives the setpoint only until bus control takes over.
      if (!s_ff.bus_ctl)
         nxt_s.setpoint = prog_pin_below ? prog_pin_code : `OFR_DEFAULT_SETPOINT; // R1

      // Bus commands.
      if (cmd_valid)
      begin
         unique case (cmd_code)
            `OFR_CMD_VOUT:
            begin
               nxt_s.setpoint = cmd_data;
               nxt_s.bus_ctl = 1'b1; // R2
            end
            `OFR_CMD_OPERATION:
               nxt_s.op_on = cmd_data[`OFR_OPERATION_ON_BIT]; // R15
            `OFR_CMD_OC_RESP:
               nxt_s.oc_latch = resp_latch(cmd_data); // R9
            `OFR_CMD_OT_RESP:
               nxt_s.ot_latch = resp_latch(cmd_data); // R9
            default:
               nxt_s.op_on = s_ff.op_on;
         endcase
      end

      // A full off interval arms the next restart; cleared when a start begins.
      if (t_cnt[`OFR_T_OFF] >= `OFR_OFF_MIN_MS)
         nxt_s.off_ok = 1'b1; // R17

      // Overvoltage window expiry with fewer than three shutdowns clears the count.
      if (t_cnt[`OFR_T_WIN] >= `OFR_OV_WINDOW_MS && s_ff.ov_cnt < `OFR_OV_MAX_TRIES)
         nxt_s.ov_cnt = 2'h0; // R13

      unique case (s_ff.state)
         OFR_ST_OFF:
         begin
            nxt_s.main_en = 1'b0;
            if (want_on && s_ff.off_ok)
            begin
               nxt_s.state = OFR_ST_AUX;
               nxt_s.off_ok = 1'b0;
            end
         end
         OFR_ST_AUX:
         begin
            // Main output waits while the standby rail leads it.
            if (!want_on)
               nxt_s.state = OFR_ST_OFF;
            else if (t_cnt[`OFR_T_STATE] >= `OFR_AUX_LEAD_MS)
            begin
               nxt_s.state = OFR_ST_ON; // R21
               nxt_s.main_en = 1'b1;
            end
         end
         OFR_ST_ON:
         begin
            nxt_s.cc_hold = in_limit && cc_window; // R3
            // Success clears alarms first so a fault in this cycle still sets.
            if (s_ff.restarting && main_in_reg)
            begin
               nxt_s.alarm = 4'h0; // R18
               nxt_s.restart_ok = 1'b1; // R18
               nxt_s.restarting = 1'b0;
            end
            if (!want_on)
            begin
               nxt_s.state = OFR_ST_OFF;
               nxt_s.main_en = 1'b0;
            end
            else if (overvoltage)
            begin
               nxt_s.main_en = 1'b0;
               nxt_s.alarm[`OFR_ALARM_OV] = 1'b1;
               nxt_s.ov_cnt = s_ff.ov_cnt + 2'h1; // R11
               nxt_s.retry_ov = 1'b1;
               if (s_ff.ov_cnt + 2'h1 >= `OFR_OV_MAX_TRIES)
                  nxt_s.state = OFR_ST_LATCH; // R12
               else
                  nxt_s.state = OFR_ST_RETRY;
            end
            else if (overtemp)
            begin
               nxt_s.main_en = 1'b0;
               nxt_s.alarm[`OFR_ALARM_OT] = 1'b1;
               nxt_s.retry_ov = 1'b0;
               nxt_s.latch_ot = s_ff.ot_latch;
               nxt_s.state = s_ff.ot_latch ? OFR_ST_LATCH : OFR_ST_RETRY; // R10
            end
            else if (in_limit && vout_below_short && !cc_window)
            begin
               // A short skips the overcurrent delay entirely.
               nxt_s.main_en = 1'b0;
               nxt_s.alarm[`OFR_ALARM_OC] = 1'b1;
               nxt_s.retry_ov = 1'b0;
               nxt_s.latch_oc = s_ff.oc_latch;
               nxt_s.state = s_ff.oc_latch ? OFR_ST_LATCH : OFR_ST_RETRY; // R8
            end
            else if (in_limit && vout_below_low && !cc_window && !s_ff.oc_latch)
            begin
               nxt_s.main_en = 1'b0;
               nxt_s.hiccup = 1'b1; // R5
               nxt_s.retry_ov = 1'b0;
               nxt_s.state = OFR_ST_RETRY;
            end
            else if (t_cnt[`OFR_T_OC] >= `OFR_OC_DELAY_MS)
            begin
               nxt_s.main_en = 1'b0;
               nxt_s.alarm[`OFR_ALARM_OC] = 1'b1; // R7
               nxt_s.retry_ov = 1'b0;
               nxt_s.latch_oc = s_ff.oc_latch;
               nxt_s.state = s_ff.oc_latch ? OFR_ST_LATCH : OFR_ST_RETRY; // R9
            end
         end
         OFR_ST_RETRY:
         begin
            // Overvoltage retries wait one second, other faults the off minimum.
            nxt_s.main_en = 1'b0;
            if (!want_on)
            begin
               nxt_s.state = OFR_ST_OFF;
               nxt_s.hiccup = 1'b0;
            end
            else if (t_cnt[`OFR_T_STATE] >= (s_ff.retry_ov ? `OFR_OV_RETRY_MS
                                                            : `OFR_OFF_MIN_MS))
            begin
               nxt_s.state = OFR_ST_AUX; // R11
               nxt_s.restarting = 1'b1;
               nxt_s.hiccup = 1'b0;
               nxt_s.off_ok = 1'b0;
            end
         end
         OFR_ST_LATCH:
         begin
            nxt_s.main_en = 1'b0;
            // Reconfiguring to auto-restart releases the latch with no off wait.
            if ((s_ff.latch_oc && !nxt_s.oc_latch) || (s_ff.latch_ot && !nxt_s.ot_latch))
            begin
               nxt_s.state = OFR_ST_AUX; // R16
               nxt_s.restarting = 1'b1;
               nxt_s.ov_cnt = 2'h0;
               nxt_s.latch_oc = 1'b0;
               nxt_s.latch_ot = 1'b0;
               nxt_s.off_ok = 1'b0;
            end
            else if (want_on && s_ff.off_ok)
            begin
               // Pin or bus was off long enough and is on again.
               nxt_s.state = OFR_ST_AUX; // R14 R15 R17
               nxt_s.restarting = 1'b1;
               nxt_s.ov_cnt = 2'h0;
               nxt_s.latch_oc = 1'b0;
               nxt_s.latch_ot = 1'b0;
               nxt_s.off_ok = 1'b0;
            end
         end
         default:
         begin
            nxt_s.state = OFR_ST_OFF;
            nxt_s.main_en = 1'b0;
         end
      endcase

      // Entering latch-off disarms restart until a fresh off interval.
      if (s_ff.state != OFR_ST_LATCH && nxt_s.state == OFR_ST_LATCH)
         nxt_s.off_ok = 1'b0; // R10

      if (input_low)
         nxt_s.alarm[`OFR_ALARM_INLOW] = 1'b1;

      // Shared blink phase for both indicators.
      if (tick)
      begin
         if (s_ff.blink_cnt >= `OFR_BLINK_MS - 16'h1)
         begin
            nxt_s.blink_cnt = 16'h0;
            nxt_s.blink_ph = !s_ff.blink_ph;
         end
         else
         begin
            nxt_s.blink_cnt = s_ff.blink_cnt + 16'h1;
         end
      end

      // Output indicator follows the state; in_limit above low voltage blinks.
      if (s_ff.state != OFR_ST_ON)
         nxt_s.out_led = 1'b0; // R6
      else if (in_limit && !vout_below_low)
         nxt_s.out_led = s_ff.blink_ph; // R4
      else
         nxt_s.out_led = 1'b1; // R6
      nxt_s.in_led = input_low ? s_ff.blink_ph : 1'b1; // R22
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         s_ff <= ST_RST;
      else
         s_ff <= nxt_s;
   end

   // All outputs come straight from the state register.
   assign output_voltage_setpoint = s_ff.setpoint;
   assign bus_control = s_ff.bus_ctl;
   assign main_enable = s_ff.main_en;
   assign standby_rail = s_ff.standby_en;
   assign cc_hold = s_ff.cc_hold;
   assign hiccup = s_ff.hiccup;
   assign latched_off = (s_ff.state == OFR_ST_LATCH);
   assign restart_ok = s_ff.restart_ok;
   assign alarm = s_ff.alarm;
   assign out_led = s_ff.out_led;
   assign in_led = s_ff.in_led;

   // Pin setpoint is taken the cycle after, unless a bus setpoint arrives.
   setpt_pin_a: assert property (@(posedge clk) disable iff (!rst_b) // R1
      !s_ff.bus_ctl && !(cmd_valid && cmd_code == `OFR_CMD_VOUT) |=>
      s_ff.setpoint == ($past(prog_pin_below) ? $past(prog_pin_code) : `OFR_DEFAULT_SETPOINT))
      else $error("setpoint does not follow the programming pin");

   bus_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // R2
      s_ff.bus_ctl && !(cmd_valid && cmd_code == `OFR_CMD_VOUT) |=>
      s_ff.bus_ctl && $stable(s_ff.setpoint))
      else $error("setpoint moved after bus control took over");

   aux_lead_a: assert property (@(posedge clk) disable iff (!rst_b) // R21
      $rose(s_ff.main_en) |-> s_ff.standby_en && $past(t_cnt[`OFR_T_STATE]) >= `OFR_AUX_LEAD_MS)
      else $error("main output enabled before standby lead time");

   led_off_a: assert property (@(posedge clk) disable iff (!rst_b) // R6
      s_ff.state != OFR_ST_ON |=> !s_ff.out_led)
      else $error("output indicator lit while unit not on");

   oc_delay_a: assert property (@(posedge clk) disable iff (!rst_b) // R7
      $rose(s_ff.alarm[`OFR_ALARM_OC]) |->
      $past(vout_below_short && in_limit) || $past(t_cnt[`OFR_T_OC]) >= `OFR_OC_DELAY_MS)
      else $error("overcurrent shutdown before its delay");

   ov_latch_a: assert property (@(posedge clk) disable iff (!rst_b) // R12
      s_ff.state == OFR_ST_ON && want_on && overvoltage && s_ff.ov_cnt == 2'h2 |=>
      s_ff.state == OFR_ST_LATCH ##1 latched_off)
      else $error("third overvoltage did not latch off");

   latch_stay_a: assert property (@(posedge clk) disable iff (!rst_b) // R10
      s_ff.state == OFR_ST_LATCH |=> s_ff.state inside {OFR_ST_LATCH, OFR_ST_AUX} && !s_ff.main_en)
      else $error("latched unit left latch-off improperly");

   restart_ok_a: assert property (@(posedge clk) disable iff (!rst_b) // R18
      $rose(s_ff.restart_ok) |-> $past(main_in_reg) && $past(s_ff.state) == OFR_ST_ON)
      else $error("restart flag set without a successful restart");

   in_blink_a: assert property (@(posedge clk) disable iff (!rst_b) // R22
      !input_low |=> s_ff.in_led)
      else $error("input indicator not steady with good input");
endmodule
`default_nettype wire

// ---- verif/ofr_host_model.sv ----
// Host controller model that issues bus commands and drives the on/off pin.
`timescale 1ns/1ps
`default_nettype none
`include "ofr_defs.svh"
module ofr_host_model (
   input wire logic clk,
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   output logic [15:0] cmd_data,
   output logic unit_enable
);
   // The unit is requested on from time zero.
   initial
   begin
      cmd_valid = 1'b0;
      cmd_code = 8'h00;
      cmd_data = 16'h0000;
      unit_enable = 1'b1;
   end

   // One command per strobe; code and data are inverted once it drops, so stale values never help.
   task automatic send(input logic [7:0] code, input logic [15:0] data);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_code = code;
      cmd_data = data;
      @(negedge clk);
      cmd_valid = 1'b0;
      cmd_code = ~code;
      cmd_data = ~data;
   endtask

   // The pin is held off for the given number of cycles, then turned on again.
   task automatic pin_cycle(input int cycles);
      @(negedge clk);
      unit_enable = 1'b0;
      repeat (cycles) @(negedge clk);
      unit_enable = 1'b1;
   endtask

   // The operation command turns the output off, waits, then turns it on.
   task automatic op_cycle(input int cycles);
      send(`OFR_CMD_OPERATION, 16'h0000);
      repeat (cycles) @(negedge clk);
      send(`OFR_CMD_OPERATION, 16'h0080);
   endtask
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking testbench of the output fault and restart supervisor.
`timescale 1ns/1ps
`default_nettype none
`include "ofr_defs.svh"
module testbench;
   // One tick is four cycles, so every millisecond figure costs four clocks.
   localparam int TC = 4;
   logic clk;
   logic rst_b;
   logic cmd_valid;
   logic [7:0] cmd_code;
   logic [15:0] cmd_data;
   logic unit_enable;
   logic prog_pin_below;
   logic [15:0] prog_pin_code;
   logic in_limit;
   logic overvoltage;
   logic overtemp;
   logic main_in_reg;
   logic input_low;
   logic [15:0] output_voltage_setpoint;
   logic bus_control;
   logic main_enable;
   logic standby_rail;
   logic cc_hold;
   logic hiccup;
   logic latched_off;
   logic restart_ok;
   logic [3:0] alarm;
   logic out_led;
   logic in_led;
   int error_cnt;
   int num_checks;
   int cyc;

   ofr_host_model i_host (
      .clk(clk),
      .cmd_valid(cmd_valid),
      .cmd_code(cmd_code),
      .cmd_data(cmd_data),
      .unit_enable(unit_enable)
   );

   ofr_supervisor #(.TICK_CYCLES(TC)) i_dut (
      .clk(clk),
      .rst_b(rst_b),
      .cmd_valid(cmd_valid),
      .cmd_code(cmd_code),
      .cmd_data(cmd_data),
      .unit_enable(unit_enable),
      .prog_pin_below(prog_pin_below),
      .prog_pin_code(prog_pin_code),
      .in_limit(in_limit),
      .overcurrent(1'b0),
      .overvoltage(overvoltage),
      .overtemp(overtemp),
      .vout_below_low(1'b0),
      .vout_below_short(1'b0),
      .main_in_reg(main_in_reg),
      .input_low(input_low),
      .output_voltage_setpoint(output_voltage_setpoint),
      .bus_control(bus_control),
      .main_enable(main_enable),
      .standby_rail(standby_rail),
      .cc_hold(cc_hold),
      .hiccup(hiccup),
      .latched_off(latched_off),
      .restart_ok(restart_ok),
      .alarm(alarm),
      .out_led(out_led),
      .in_led(in_led)
   );

   // A 200 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // The output reaches regulation one cycle after it is enabled, like a fast plant.
   always @(negedge clk) main_in_reg <= main_enable;

   // A hang is cut short well after the longest expected run.
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 100000)
      begin
         error_cnt++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("Checks %0d, errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Waits for the main output under a bounded count of cycles.
   task automatic wait_main(input int max, output int n);
      n = 0;
      while (main_enable !== 1'b1 && n < max)
      begin
         @(negedge clk);
         n++;
      end
   endtask

   // Holds overtemperature for two cycles, then checks the output dropped.
   task automatic trip_ot();
      overtemp = 1'b1;
      repeat (2) @(negedge clk);
      overtemp = 1'b0;
      check("ot trip", 16'(main_enable), 16'h0000);
      check("ot alarm", 16'(alarm[`OFR_ALARM_OT]), 16'h0001);
   endtask

   task automatic t_power();
      int n;
      @(negedge clk);
      check("standby early", 16'(standby_rail), 16'h0001);
      check("no restart flag", 16'(restart_ok), 16'h0000);
      wait_main(3000 * TC, n);
      check("aux lead", 16'(n >= (`OFR_AUX_LEAD_MS - 1) * TC && n <= (`OFR_AUX_LEAD_MS + 1) * TC + 3), 16'h0001);
   endtask

   task automatic t_setpoint();
      prog_pin_code = 16'h1234;
      prog_pin_below = 1'b1;
      repeat (3) @(negedge clk);
      check("pin setpoint", output_voltage_setpoint, 16'h1234);
      prog_pin_below = 1'b0;
      repeat (3) @(negedge clk);
      check("default setpoint", output_voltage_setpoint, `OFR_DEFAULT_SETPOINT);
      i_host.send(`OFR_CMD_VOUT, 16'h2a5c);
      @(negedge clk);
      check("bus setpoint", output_voltage_setpoint, 16'h2a5c);
      check("bus control", 16'(bus_control), 16'h0001);
      prog_pin_below = 1'b1;
      repeat (3) @(negedge clk);
      check("pin ignored", output_voltage_setpoint, 16'h2a5c);
   endtask

   task automatic t_leds();
      int to;
      int ti;
      logic po;
      logic pi;
      check("out led on", 16'(out_led), 16'h0001);
      in_limit = 1'b1;
      input_low = 1'b1;
      repeat (2) @(negedge clk);
      to = 0;
      ti = 0;
      po = out_led;
      pi = in_led;
      repeat (1100 * TC)
      begin
         @(negedge clk);
         to += int'(out_led !== po);
         ti += int'(in_led !== pi);
         po = out_led;
         pi = in_led;
      end
      check("cc hold", 16'(cc_hold), 16'h0001);
      check("kept on", 16'(main_enable), 16'h0001);
      check("out blink", 16'(to >= 2 && to <= 3), 16'h0001);
      check("in blink", 16'(ti >= 2 && ti <= 3), 16'h0001);
      in_limit = 1'b0;
      input_low = 1'b0;
      repeat (2 * TC) @(negedge clk);
      check("out led steady", 16'(out_led), 16'h0001);
      check("in led steady", 16'(in_led), 16'h0001);
   endtask

   task automatic t_ot_auto();
      int n;
      trip_ot();
      check("ot no latch", 16'(latched_off), 16'h0000);
      wait_main(2600 * TC, n);
      check("ot auto restart", 16'(main_enable), 16'h0001);
      check("ot off time", 16'(n >= (`OFR_OFF_MIN_MS - 1) * TC), 16'h0001);
      repeat (4) @(negedge clk);
      check("alarm cleared", 16'(alarm), 16'h0000);
      check("first restart flag", 16'(restart_ok), 16'h0001);
   endtask

   task automatic t_ot_latch();
      int n;
      i_host.send(`OFR_CMD_OT_RESP, 16'h0040);
      trip_ot();
      check("ot latched", 16'(latched_off), 16'h0001);
      check("led off latched", 16'(out_led), 16'h0000);
      repeat (2100 * TC) @(negedge clk);
      check("stays off", 16'(main_enable), 16'h0000);
      i_host.send(`OFR_CMD_OT_RESP, 16'h0000);
      @(negedge clk);
      check("latch released", 16'(latched_off), 16'h0000);
      wait_main(500 * TC, n);
      check("fast restart", 16'(main_enable), 16'h0001);
   endtask

   task automatic t_op_restart();
      int n;
      i_host.send(`OFR_CMD_OT_RESP, 16'h0040);
      trip_ot();
      i_host.op_cycle(500 * TC);
      wait_main(600 * TC, n);
      check("short off refused", 16'(main_enable), 16'h0000);
      i_host.op_cycle(2010 * TC);
      wait_main(600 * TC, n);
      check("op restart", 16'(main_enable), 16'h0001);
      i_host.send(`OFR_CMD_OT_RESP, 16'h0000);
   endtask

   task automatic t_ov();
      int n;
      for (int k = 1; k <= 3; k++)
      begin
         overvoltage = 1'b1;
         @(negedge clk);
         overvoltage = 1'b0;
         @(negedge clk);
         check("ov trip", 16'(main_enable), 16'h0000);
         check("ov alarm", 16'(alarm[`OFR_ALARM_OV]), 16'h0001);
         if (k < 3)
         begin
            repeat (1400 * TC) @(negedge clk);
            check("ov retry wait", 16'(main_enable), 16'h0000);
            wait_main(700 * TC, n);
            check("ov retry", 16'(main_enable), 16'h0001);
         end
         else
         begin
            check("ov latched", 16'(latched_off), 16'h0001);
            check("led off latched", 16'(out_led), 16'h0000);
         end
      end
   endtask

   task automatic t_pin_restart();
      int n;
      i_host.pin_cycle(1000 * TC);
      wait_main(600 * TC, n);
      check("short pin refused", 16'(main_enable), 16'h0000);
      i_host.pin_cycle(2010 * TC);
      wait_main(600 * TC, n);
      check("pin restart", 16'(main_enable), 16'h0001);
      repeat (4) @(negedge clk);
      check("alarm cleared", 16'(alarm), 16'h0000);
      check("restart flag", 16'(restart_ok), 16'h0001);
   endtask

   // Reset is held for ten cycles with every input at a quiet level.
   initial
   begin
      error_cnt = 0;
      num_checks = 0;
      rst_b = 1'b0;
      prog_pin_below = 1'b0;
      prog_pin_code = 16'h0000;
      in_limit = 1'b0;
      overvoltage = 1'b0;
      overtemp = 1'b0;
      input_low = 1'b0;
      repeat (10) @(negedge clk);
      check("reset setpoint", output_voltage_setpoint, `OFR_DEFAULT_SETPOINT);
      rst_b = 1'b1;
      t_power();
      t_setpoint();
      t_leds();
      t_ot_auto();
      t_ot_latch();
      t_op_restart();
      t_ov();
      t_pin_restart();
      report_and_stop();
   end
endmodule
`default_nettype wire
